// file: shared/cb_consts.vh
// Constants for the processor bus read/write cycle engine
`ifndef CB_CONSTS_VH
`define CB_CONSTS_VH

// ----------------------------------------------------------------
// Access status codes
// ----------------------------------------------------------------
`define CB_SAS_WRITE      4'hA
`define CB_SAS_NOP        4'hF

// ----------------------------------------------------------------
// Direction levels and idle values
// ----------------------------------------------------------------
`define CB_DIR_READ       1'b1
`define CB_DIR_WRITE      1'b0
`define CB_ADDR_IDLE      32'h00000000
`define CB_SIZE_IDLE      2'h0

// ----------------------------------------------------------------
// Synchroniser depth and control sample vector layout
// ----------------------------------------------------------------
`define CB_SYNC_STAGES    2
`define CB_CTRL_WIDTH     11
`define CB_EXC_FAULT      0
`define CB_EXC_RETRY      1
`define CB_EXC_YIELD      2

`endif

// file: hw/cb_sync.v
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module cb_sync #(
    parameter WIDTH    = 1,
    parameter RST_VAL  = 0
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] d_in,
    output reg  [WIDTH-1:0] q_out
);
    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_q <= {WIDTH{RST_VAL[0]}};
            q_out  <= {WIDTH{RST_VAL[0]}};
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // cb_sync

// file: hw/cb_ack_sampler.v
// Acknowledge and exception sampler for one bus transaction
`timescale 1ns/100ps
module cb_ack_sampler (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       clear,
    input  wire       async_pt,
    input  wire       sync_pt,
    input  wire       async_ack,
    input  wire [2:0] async_exc,
    input  wire       sync_ack,
    input  wire [2:0] sync_exc,
    input  wire       dbl_ack,
    output wire       ack_d,
    output wire [2:0] exc_d,
    output reg        ack_q,
    output reg  [2:0] exc_q,
    output reg        dbl_q
);
    wire async_hit;
    wire sync_hit;

    // Only the first acknowledge counts; later samples are ignored
    assign async_hit = async_pt & async_ack & ~ack_q;
    assign sync_hit  = sync_pt & sync_ack & ~ack_q & ~async_hit;
    assign ack_d     = ack_q | async_hit | sync_hit;
    // Exceptions taken once, from the path whose acknowledge won
    assign exc_d     = async_hit ? async_exc : (sync_hit ? sync_exc : exc_q);

    always @(posedge core_clk)
    begin
        if (rst || clear)
        begin
            ack_q <= 1'b0;
            exc_q <= 3'h0;
            dbl_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
            exc_q <= exc_d;
            // Double fetch is taken once, at the synchronous point on or after the acknowledge
            if (sync_pt && ack_d)
            begin
                dbl_q <= dbl_ack;
            end
        end
    end
endmodule // cb_ack_sampler

// file: hw/cb_bus_cycle.v
// Bus master engine for processor read and write transactions
`timescale 1ns/100ps
`include "cb_consts.vh"
module cb_bus_cycle #(
    parameter [3:0] NOP_CODE = `CB_SAS_NOP
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        req_valid,
    output wire        req_ready,
    input  wire        req_write,
    input  wire [31:0] req_addr,
    input  wire [1:0]  req_size,
    input  wire [3:0]  req_status,
    input  wire [31:0] req_wdata,
    input  wire        virtual_mode,
    output reg         rsp_valid,
    output reg  [31:0] rsp_rdata,
    output reg  [2:0]  rsp_exc,
    output reg         rsp_dbl,
    output reg  [31:0] location_bus,
    output reg         location_bus_oe_n,
    output reg  [1:0]  transfer_size,
    output reg         dir_read,
    output reg  [3:0]  access_status_code,
    output reg         cycle_begin_n,
    output reg         address_strobe_n,
    output reg         data_strobe_n,
    output reg         data_done_out_n,
    output reg  [31:0] data_out,
    output reg         data_oe_n,
    input  wire [31:0] data_in,
    input  wire        async_transfer_ack_n,
    input  wire        sync_ready_in_n,
    input  wire        fault_in_n,
    input  wire        retry_in_n,
    input  wire        yield_retry_req_n,
    input  wire        double_fetch_ack_n,
    input  wire        bus_request_in_n,
    input  wire        bus_grant_ack_n,
    input  wire [3:0]  irq_level_in_n,
    input  wire        nonmask_irq_n,
    input  wire        auto_vector_in_n,
    input  wire        irq_option_in_n,
    input  wire        stop_in_n,
    input  wire        reset_request_in_n,
    output reg         clock_phase_a,
    output reg         clock_phase_b,
    output reg  [10:0] sampled_ctrl
);
    // ----------------------------------------------------------------
    // State codes, one per clock state
    // ----------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_PRE0 = 4'h1;
    localparam [3:0] ST_PRE1 = 4'h2;
    localparam [3:0] ST_S0   = 4'h3;
    localparam [3:0] ST_S1   = 4'h4;
    localparam [3:0] ST_S2   = 4'h5;
    localparam [3:0] ST_S3   = 4'h6;
    localparam [3:0] ST_S4   = 4'h7;
    localparam [3:0] ST_S5   = 4'h8;
    localparam [3:0] ST_W0   = 4'h9;
    localparam [3:0] ST_W1   = 4'hA;
    localparam [3:0] ST_E0   = 4'hB;
    localparam [3:0] ST_E1   = 4'hC;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg         phase_q;
    reg         wr_q;
    reg  [31:0] addr_q;
    reg  [1:0]  size_q;
    reg  [3:0]  code_q;
    reg  [31:0] wdata_q;
    reg         virt_q;
    wire        accept;
    wire [3:0]  ack_exc_s;
    wire [10:0] ctrl_s;
    wire        ack_d;
    wire [2:0]  exc_d;
    wire        ack_q;
    wire [2:0]  exc_q;
    wire        dbl_q;
    wire        in_txn;
    wire        in_wait;

    // Active-state tests used by several outputs
    function in_set;
        input [3:0] s;
        input [3:0] lo;
        input [3:0] hi;
        begin
            in_set = (s >= lo) && (s <= hi);
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Async acknowledge and its exceptions share one two-stage latch
    cb_sync #(
        .WIDTH   (4),
        .RST_VAL (0)
    ) u_ack_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d_in     ({~yield_retry_req_n, ~retry_in_n, ~fault_in_n, ~async_transfer_ack_n}),
        .q_out    (ack_exc_s)
    );

    cb_sync #(
        .WIDTH   (`CB_CTRL_WIDTH),
        .RST_VAL (0)
    ) u_ctrl_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d_in     ({~bus_request_in_n, ~bus_grant_ack_n, ~irq_level_in_n, ~nonmask_irq_n,
                    ~auto_vector_in_n, ~irq_option_in_n, ~stop_in_n, ~reset_request_in_n}),
        .q_out    (ctrl_s)
    );

    // ----------------------------------------------------------------
    // Acknowledge sampling points
    // ----------------------------------------------------------------
    // Sync ready and its exceptions are taken raw: they meet setup to core_clk
    cb_ack_sampler u_sampler (
        .core_clk  (core_clk),
        .rst       (rst),
        .clear     (state_q == ST_S0),
        .async_pt  ((state_q == ST_S2) || (state_q == ST_W0)),
        .sync_pt   ((state_q == ST_S3) || (state_q == ST_W1)),
        .async_ack (ack_exc_s[0]),
        .async_exc (ack_exc_s[3:1]),
        .sync_ack  (~sync_ready_in_n),
        .sync_exc  ({~yield_retry_req_n, ~retry_in_n, ~fault_in_n}),
        .dbl_ack   (~double_fetch_ack_n),
        .ack_d     (ack_d),
        .exc_d     (exc_d),
        .ack_q     (ack_q),
        .exc_q     (exc_q),
        .dbl_q     (dbl_q)
    );

    // ----------------------------------------------------------------
    // Clock states and control sampling
    // ----------------------------------------------------------------
    // Even states start a bus clock cycle; phase_q high marks its second half
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            phase_q       <= 1'b0;
            clock_phase_a <= 1'b0;
            clock_phase_b <= 1'b0;
            sampled_ctrl  <= 11'h000;
        end
        else
        begin
            phase_q       <= ~phase_q;
            clock_phase_a <= ~phase_q;
            clock_phase_b <= clock_phase_a;
            if (phase_q)
            begin
                sampled_ctrl <= ctrl_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // New work only at a cycle boundary so state zero lands on an even state
    assign accept    = req_valid && (((state_q == ST_IDLE) && phase_q) || (state_q == ST_E1));
    assign req_ready = ((state_q == ST_IDLE) && phase_q) || (state_q == ST_E1);

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = accept ? ST_PRE0 : ST_IDLE;
            ST_PRE0: state_d = ST_PRE1;
            ST_PRE1: state_d = ST_S0;
            ST_S0:   state_d = ST_S1;
            ST_S1:   state_d = ST_S2;
            ST_S2:   state_d = ST_S3;
            ST_S3:   state_d = ack_d ? ST_S4 : ST_W0;
            ST_W0:   state_d = ST_W1;
            ST_W1:   state_d = ack_d ? ST_S4 : ST_W0;
            ST_S4:   state_d = ST_S5;
            ST_S5:   state_d = ST_E0;
            ST_E0:   state_d = ST_E1;
            ST_E1:   state_d = accept ? ST_PRE0 : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            wr_q    <= 1'b0;
            addr_q  <= `CB_ADDR_IDLE;
            size_q  <= `CB_SIZE_IDLE;
            code_q  <= NOP_CODE;
            wdata_q <= 32'h00000000;
            virt_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (accept)
            begin
                wr_q    <= req_write;
                addr_q  <= req_addr;
                size_q  <= req_size;
                code_q  <= req_write ? `CB_SAS_WRITE : req_status;
                wdata_q <= req_wdata;
                virt_q  <= virtual_mode;
            end
        end
    end

    assign in_txn   = in_set(state_d, ST_S0, ST_W1);
    assign in_wait  = (state_d == ST_W0) || (state_d == ST_W1);

    // ----------------------------------------------------------------
    // Pin outputs, registered against the state being entered
    // ----------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            location_bus       <= `CB_ADDR_IDLE;
            location_bus_oe_n  <= 1'b1;
            transfer_size      <= `CB_SIZE_IDLE;
            dir_read           <= `CB_DIR_READ;
            access_status_code <= NOP_CODE;
            cycle_begin_n      <= 1'b1;
            address_strobe_n   <= 1'b1;
            data_strobe_n      <= 1'b1;
            data_done_out_n    <= 1'b1;
            data_out           <= 32'h00000000;
            data_oe_n          <= 1'b1;
        end
        else
        begin
            // Address, size and direction held from state zero through the tail
            if (state_d == ST_S0)
            begin
                location_bus  <= addr_q;
                transfer_size <= size_q;
                dir_read      <= wr_q ? `CB_DIR_WRITE : `CB_DIR_READ;
            end
            // Virtual mode releases the address after state one for translation
            location_bus_oe_n <= ~(in_txn && (!virt_q || in_set(state_d, ST_S0, ST_S1)));
            cycle_begin_n     <= ~in_set(state_d, ST_S0, ST_S3);
            address_strobe_n  <= ~(in_set(state_d, ST_S1, ST_S4) || in_wait);
            // Read strobes match; write data strobe trails by one cycle
            data_strobe_n     <= ~((wr_q ? in_set(state_d, ST_S3, ST_S4)
                                         : in_set(state_d, ST_S1, ST_S4)) || in_wait);
            // Status code: one cycle ahead, then two cycles
            if (state_d == ST_PRE0)
            begin
                access_status_code <= accept ? (req_write ? `CB_SAS_WRITE : req_status)
                                             : code_q;
            end
            else if (state_d == ST_S4)
            begin
                // Look ahead to a queued request
                access_status_code <= req_valid ? (req_write ? `CB_SAS_WRITE : req_status)
                                                : NOP_CODE;
            end
            else if (state_d == ST_IDLE)
            begin
                access_status_code <= NOP_CODE;
            end
            data_done_out_n <= ~(in_set(state_d, ST_S4, ST_S5) && (exc_d == 3'h0));
            // Write data from state two to the end of the transaction
            data_oe_n <= ~(wr_q && (in_set(state_d, ST_S2, ST_S5) || in_wait));
            if (state_d == ST_S2)
            begin
                data_out <= wdata_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read capture and response
    // ----------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 32'h00000000;
            rsp_exc   <= 3'h0;
            rsp_dbl   <= 1'b0;
        end
        else
        begin
            rsp_valid <= (state_q == ST_S4);
            if (state_q == ST_S4)
            begin
                // Data bus is valid while the strobes close
                if (!wr_q)
                begin
                    rsp_rdata <= data_in;
                end
                rsp_exc <= exc_q;
                rsp_dbl <= dbl_q;
            end
        end
    end
endmodule // cb_bus_cycle

// file: bench/cb_bus_cycle_asserts.sv
// Concurrent checks on the bus cycle engine pins
`timescale 1ns/100ps
`include "cb_consts.vh"
module cb_bus_cycle_asserts (
    input wire       core_clk,
    input wire       rst,
    input wire       virtual_mode,
    input wire       rsp_valid,
    input wire [2:0] rsp_exc,
    input wire       location_bus_oe_n,
    input wire [1:0] transfer_size,
    input wire       dir_read,
    input wire [3:0] access_status_code,
    input wire       cycle_begin_n,
    input wire       address_strobe_n,
    input wire       data_strobe_n,
    input wire       data_done_out_n,
    input wire       data_oe_n,
    input wire       clock_phase_a,
    input wire       clock_phase_b
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // -------------------------------------------------------------
    // Transaction framing
    // -------------------------------------------------------------
    a_cycle_begin_len: assert property (
        $fell(cycle_begin_n) |-> !cycle_begin_n [*4] ##1 cycle_begin_n)
        else $error("cycle begin width wrong");
    a_status_held: assert property (
        $fell(cycle_begin_n) |-> $stable(access_status_code) [*4])
        else $error("status code not held");
    a_write_code: assert property (
        $fell(cycle_begin_n) && !dir_read |-> access_status_code == `CB_SAS_WRITE)
        else $error("write status code wrong");
    a_write_ds_late: assert property (
        $fell(address_strobe_n) && !dir_read |-> data_strobe_n [*2] ##1 !data_strobe_n)
        else $error("write data strobe timing wrong");
    a_read_strobes: assert property (
        dir_read |-> address_strobe_n == data_strobe_n)
        else $error("read strobes differ");
    a_dir_size_stable: assert property (
        !address_strobe_n |-> $stable(dir_read) && $stable(transfer_size))
        else $error("direction or size moved");
    a_addr_release: assert property (
        $fell(cycle_begin_n) |-> !location_bus_oe_n ##2 location_bus_oe_n == virtual_mode)
        else $error("address drive wrong");
    a_done_no_exc: assert property (
        rsp_valid |-> data_done_out_n == (rsp_exc != 3'h0))
        else $error("data done against exception wrong");
    a_write_data_drive: assert property (
        $fell(cycle_begin_n) && !dir_read |-> data_oe_n [*2] ##1 !data_oe_n)
        else $error("write data drive start wrong");
    a_read_no_drive: assert property (
        dir_read |-> data_oe_n)
        else $error("data bus driven during read");
    a_bus_release_gap: assert property (
        $rose(address_strobe_n) |-> cycle_begin_n [*5])
        else $error("no release cycle after access");
    a_phase_toggle: assert property (
        !$past(rst) |-> clock_phase_a != $past(clock_phase_a)
                        && clock_phase_b == $past(clock_phase_a))
        else $error("clock state phases wrong");

    cover property ($fell(cycle_begin_n) && !dir_read);
    cover property ($fell(cycle_begin_n) && virtual_mode);
    cover property (rsp_valid && rsp_exc != 3'h0);
endmodule // cb_bus_cycle_asserts

bind cb_bus_cycle cb_bus_cycle_asserts u_chk (.core_clk, .rst, .virtual_mode, .rsp_valid,
    .rsp_exc, .location_bus_oe_n, .transfer_size, .dir_read, .access_status_code,
    .cycle_begin_n, .address_strobe_n, .data_strobe_n, .data_done_out_n, .data_oe_n,
    .clock_phase_a, .clock_phase_b);

// file: bench/cb_slave_model.sv
// Memory slave answering bus transactions with chosen waits and ack kind
`timescale 1ns/100ps
module cb_slave_model (
    input  wire        core_clk,
    input  wire        cycle_begin_n,
    input  wire        address_strobe_n,
    input  wire        data_strobe_n,
    input  wire        dir_read,
    input  wire [31:0] data_out,
    input  wire [31:0] rd_word,
    input  wire        use_async,
    input  wire [1:0]  waits,
    input  wire [2:0]  exc,
    input  wire        dbl,
    output wire [31:0] data_in,
    output wire        async_transfer_ack_n,
    output wire        sync_ready_in_n,
    output wire [2:0]  exc_n,
    output wire        double_fetch_ack_n,
    output reg  [31:0] wr_cap
);
    integer cnt = 0;
    reg     dbl_hold = 1'b0;
    wire    busy = !cycle_begin_n || !address_strobe_n;
    // Async ack leads by three states: two for the two-stage latch, one for the earlier sample point
    wire    aack = busy && use_async && cnt >= 2 * waits;
    wire    sack = busy && !use_async && cnt == 3 + 2 * waits;
    wire    ack = aack || sack;

    always @(posedge core_clk)
    begin
        cnt <= busy ? cnt + 1 : 0;
        dbl_hold <= (ack || dbl_hold) && !data_strobe_n;
        if (!data_strobe_n && !dir_read)
            wr_cap <= data_out;
    end

    assign async_transfer_ack_n = !aack;
    assign sync_ready_in_n = !sack;
    assign exc_n = ack ? ~exc : 3'h7;
    assign double_fetch_ack_n = !(dbl && (ack || dbl_hold) && !data_strobe_n);
    // Released bus shows the inverse so stale data cannot pass
    assign data_in = (!data_strobe_n && dir_read) ? rd_word : ~rd_word;
endmodule // cb_slave_model

// file: bench/cb_bus_cycle_bench.sv
// Self-checking bench for the bus cycle engine
`timescale 1ns/100ps
`include "cb_consts.vh"
module cb_bus_cycle_bench;
    reg         core_clk = 1'b0;
    reg         rst = 1'b1;
    reg         req_valid = 1'b0;
    reg         req_write = 1'b0;
    reg  [31:0] req_addr = 32'h0;
    reg  [1:0]  req_size = 2'h0;
    reg  [3:0]  req_status = 4'h0;
    reg  [31:0] req_wdata = 32'h0;
    reg         virtual_mode = 1'b0;
    reg  [10:0] ctrl_n = 11'h7FF;
    reg  [31:0] rd_word = 32'h0;
    reg         use_async = 1'b0;
    reg  [1:0]  waits = 2'h0;
    reg  [2:0]  exc = 3'h0;
    reg         dbl = 1'b0;
    wire        req_ready, rsp_valid, rsp_dbl, dir_read, location_bus_oe_n;
    wire        cycle_begin_n, address_strobe_n, data_strobe_n;
    wire        async_transfer_ack_n, sync_ready_in_n, double_fetch_ack_n;
    wire [31:0] rsp_rdata, location_bus, data_out, data_in, wr_cap;
    wire [2:0]  rsp_exc, exc_n;
    wire [1:0]  transfer_size;
    wire [3:0]  access_status_code;
    wire [10:0] sampled_ctrl;
    integer     err_total = 0;
    integer     total_checks = 0;
    integer     as_cnt = 0;
    integer     as_len = 0;
    integer     i, t;
    reg  [31:0] seen_addr;
    reg  [2:0]  seen_dir_size;
    reg  [3:0]  seen_code;
    reg         cb_q = 1'b1;
    reg  [31:0] exp_q[$];

    cb_bus_cycle uut (.core_clk, .rst, .req_valid, .req_ready, .req_write, .req_addr,
        .req_size, .req_status, .req_wdata, .virtual_mode, .rsp_valid, .rsp_rdata,
        .rsp_exc, .rsp_dbl, .location_bus, .location_bus_oe_n, .transfer_size,
        .dir_read, .access_status_code, .cycle_begin_n, .address_strobe_n,
        .data_strobe_n, .data_done_out_n(), .data_out, .data_oe_n(), .data_in,
        .async_transfer_ack_n, .sync_ready_in_n, .fault_in_n(exc_n[0]),
        .retry_in_n(exc_n[1]), .yield_retry_req_n(exc_n[2]), .double_fetch_ack_n,
        .bus_request_in_n(ctrl_n[10]), .bus_grant_ack_n(ctrl_n[9]),
        .irq_level_in_n(ctrl_n[8:5]), .nonmask_irq_n(ctrl_n[4]),
        .auto_vector_in_n(ctrl_n[3]), .irq_option_in_n(ctrl_n[2]),
        .stop_in_n(ctrl_n[1]), .reset_request_in_n(ctrl_n[0]),
        .clock_phase_a(), .clock_phase_b(), .sampled_ctrl);

    cb_slave_model slv (.core_clk, .cycle_begin_n, .address_strobe_n, .data_strobe_n,
        .dir_read, .data_out, .rd_word, .use_async, .waits, .exc, .dbl, .data_in,
        .async_transfer_ack_n, .sync_ready_in_n, .exc_n, .double_fetch_ack_n, .wr_cap);

    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    // -------------------------------------------------------------
    // Pin monitor: values seen are those of the state just ending
    // -------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!cycle_begin_n && cb_q)
        begin
            seen_addr = location_bus;
            seen_dir_size = {dir_read, transfer_size};
            seen_code = access_status_code;
        end
        cb_q = cycle_begin_n;
        if (!address_strobe_n)
            as_cnt = as_cnt + 1;
        else if (as_cnt != 0)
        begin
            as_len = as_cnt;
            as_cnt = 0;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // One whole transaction; wait count walks 0 to 2 and both ack kinds are used
    task run_txn(input integer k);
        integer n;
        begin
            @(posedge core_clk);
            req_valid <= 1'b1;
            req_write <= k[0];
            use_async <= k[2];
            waits <= k % 3;
            req_addr <= $urandom;
            req_size <= $urandom;
            req_status <= $urandom;
            req_wdata <= $urandom;
            virtual_mode <= $urandom;
            ctrl_n <= $urandom;
            rd_word <= $urandom;
            dbl <= $urandom;
            exc <= ($urandom % 4 == 0) ? (3'h1 << ($urandom % 3)) : 3'h0;
            n = 0;
            do
            begin
                @(posedge core_clk);
                n = n + 1;
            end while (req_ready !== 1'b1 && n < 40);
            req_valid <= 1'b0;
            // A slow answer is still bounded: 80 edges covers two waits
            while (rsp_valid !== 1'b1 && n < 80)
            begin
                @(posedge core_clk);
                n = n + 1;
            end
            if (n >= 80)
            begin
                err_total = err_total + 1;
                $display("ERROR %0t no answer", $time);
                final_report;
            end
            @(negedge core_clk);
            chk(as_len, 4 + 2 * waits);
            chk(seen_addr, req_addr);
            chk(seen_dir_size, {~req_write, req_size});
            chk(rsp_exc, exc);
            chk(rsp_dbl, dbl);
            chk(sampled_ctrl, {~ctrl_n});
            chk(seen_code, req_write ? `CB_SAS_WRITE : req_status);
            chk(access_status_code, `CB_SAS_NOP);
            exp_q.push_back(req_write ? req_wdata : rd_word);
            if (req_write || exc == 3'h0)
                chk(req_write ? wr_cap : rsp_rdata, exp_q.pop_front());
            else
                t = exp_q.pop_front();
        end
    endtask

    initial
    begin
        t = $urandom(32'h85a06935);
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 60; i = i + 1)
            run_txn(i);
        final_report;
    end
endmodule // cb_bus_cycle_bench
